//--- pkg/data_space_defines.svh
// Offsets, field positions, reset values and timing counts for the data space map
`ifndef DATA_SPACE_DEFINES_SVH
`define DATA_SPACE_DEFINES_SVH

// Data space locations
`define WINDOW_BASE 8'h40
`define WINDOW_LAST 8'h7F
`define POINTER_ONE_ADDR 8'h80
`define POINTER_TWO_ADDR 8'h81
`define SHORT_REG_ONE_ADDR 8'h82
`define SHORT_REG_SECOND_ADDR 8'h83
`define ROM_WINDOW_SELECT_ADDR 8'hC9
`define RESULT_REG_ADDR 8'hFF

// Window field layout
`define WINDOW_OFFSET_MSB 5
`define BLOCK_SELECT_MSB 5
`define BLOCK_SELECT_RESET 6'h00

// Program memory map
`define PM_LAST 12'hFFF
`define USER_FIRST_1K 12'hBA0
`define USER_FIRST_2K 12'h880
`define USER_LAST 12'hF9F
`define IRQ_VECTOR_FIRST 12'hFF0
`define IRQ_VECTOR_LAST 12'hFF7
`define NMI_VECTOR 12'hFFC
`define RESET_VECTOR 12'hFFE

// Timing
`define CPU_CYCLE_NS 10
`define SHORT_DIRECT_CPU_CYCLES 4
`define SHORT_DIRECT_CLKS 3'd4

`endif

//--- pkg/data_space_pkg.sv
// Types shared by the data space map and its program memory
package data_space_pkg;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} data_req_s;

	typedef enum logic [2:0] {
		PC_HOLD,
		PC_STEP,
		PC_JUMP,
		PC_RELATIVE,
		PC_VECTOR,
		PC_POP
	} pc_op_e;

	typedef enum logic [2:0] {
		VEC_IRQ0,
		VEC_IRQ1,
		VEC_IRQ2,
		VEC_IRQ3,
		VEC_NMI,
		VEC_RESET
	} vector_e;

	typedef struct packed {
		pc_op_e op;
		logic [11:0] target;
		logic [7:0] offset;
		vector_e vec;
	} pc_cmd_s;

	typedef struct packed {
		logic req;
		logic wr;
		logic [1:0] sel;
		logic [7:0] wdata;
	} short_req_s;

	typedef struct packed {
		logic en;
		logic [11:0] addr;
		logic [7:0] data;
	} pm_load_s;

endpackage : data_space_pkg

//--- rtl/program_store.sv
// Program memory array with one load port and two registered read ports
`timescale 1ns/1ns
module program_store
	import data_space_pkg::*;
(
	input wire logic ref_clk,
	input wire data_space_pkg::pm_load_s load,
	input wire logic [11:0] rd_addr_a,
	input wire logic [11:0] rd_addr_b,
	output logic [7:0] rd_data_a,
	output logic [7:0] rd_data_b
);
	logic [7:0] mem [0:4095];

	// No reset on the array or read registers: reads are qualified by valids upstream
	always_ff @(posedge ref_clk) begin
		if (load.en) begin
			mem[load.addr] <= load.data;
		end
		rd_data_a <= mem[rd_addr_a];
		rd_data_b <= mem[rd_addr_b];
	end
endmodule : program_store

//--- rtl/data_space_map.sv
// Data space decoder, read-only window, CPU register file and program counter
`timescale 1ns/1ns
module data_space_map
	import data_space_pkg::*;
#(
	parameter bit VARIANT_2K = 1'b0
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire data_space_pkg::data_req_s data_req,
	input wire data_space_pkg::short_req_s short_req,
	input wire data_space_pkg::pc_cmd_s pc_cmd,
	input wire logic [11:0] pop_addr,
	input wire logic fetch_en,
	input wire data_space_pkg::pm_load_s pm_load,
	output logic [7:0] rdata_q,
	output logic rvalid_q,
	output logic [7:0] short_rdata_q,
	output logic short_done_q,
	output logic short_busy_q,
	output logic [7:0] result_q,
	output logic [11:0] pc_q,
	output logic [7:0] fetch_data_q,
	output logic fetch_valid_q,
	output logic fetch_reserved_q
);
	`include "data_space_defines.svh"

	// ==========================================================
	// Data space decode
	logic [7:0] pointer_one_q;
	logic [7:0] pointer_two_q;
	logic [7:0] short_reg_one_q;
	logic [7:0] short_reg_second_q;
	logic [7:0] result_reg_q;
	logic [`BLOCK_SELECT_MSB:0] rom_window_select_q;

	wire hit_window = data_req.addr >= `WINDOW_BASE && data_req.addr <= `WINDOW_LAST;
	wire hit_p1 = data_req.addr == `POINTER_ONE_ADDR;
	wire hit_p2 = data_req.addr == `POINTER_TWO_ADDR;
	wire hit_s1 = data_req.addr == `SHORT_REG_ONE_ADDR;
	wire hit_s2 = data_req.addr == `SHORT_REG_SECOND_ADDR;
	wire hit_sel = data_req.addr == `ROM_WINDOW_SELECT_ADDR;
	wire hit_acc = data_req.addr == `RESULT_REG_ADDR;

	wire [11:0] window_addr = {rom_window_select_q, data_req.addr[`WINDOW_OFFSET_MSB:0]};

	// The select register is write-only: a read of C9h returns zero, never its contents
	wire [7:0] reg_rdata = hit_p1 ? pointer_one_q :
		hit_p2 ? pointer_two_q :
		hit_s1 ? short_reg_one_q :
		hit_s2 ? short_reg_second_q :
		hit_acc ? result_reg_q : 8'h00;

	// ==========================================================
	// Short direct access sequencer
	logic [2:0] short_cnt_q;
	logic short_wr_q;
	logic [1:0] short_sel_q;
	logic [7:0] short_wdata_q;

	wire short_start = short_req.req && !short_busy_q;
	wire short_last = short_busy_q && short_cnt_q == `SHORT_DIRECT_CLKS - 3'd1;
	// Pointers take selector codes 0 and 1, the short registers codes 2 and 3
	wire [7:0] short_cur = short_sel_q == 2'd0 ? pointer_one_q :
		short_sel_q == 2'd1 ? pointer_two_q :
		short_sel_q == 2'd2 ? short_reg_one_q : short_reg_second_q;
	wire short_wr_now = short_last && short_wr_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			short_busy_q <= 1'b0;
			short_cnt_q <= 3'd0;
			short_wr_q <= 1'b0;
			short_sel_q <= 2'd0;
			short_wdata_q <= 8'h00;
			short_done_q <= 1'b0;
			short_rdata_q <= 8'h00;
		end else begin
			short_done_q <= short_last;
			if (short_start) begin
				short_busy_q <= 1'b1;
				short_cnt_q <= 3'd0;
				short_wr_q <= short_req.wr;
				short_sel_q <= short_req.sel;
				short_wdata_q <= short_req.wdata;
			end else if (short_last) begin
				short_busy_q <= 1'b0;
				short_rdata_q <= short_cur;
			end else if (short_busy_q) begin
				short_cnt_q <= short_cnt_q + 3'd1;
			end
		end
	end

	// ==========================================================
	// Register file
	// Reset values are undefined on the real part; zero is used so that state is known
	wire dwr = data_req.wr;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pointer_one_q <= 8'h00;
			pointer_two_q <= 8'h00;
			short_reg_one_q <= 8'h00;
			short_reg_second_q <= 8'h00;
			result_reg_q <= 8'h00;
			rom_window_select_q <= `BLOCK_SELECT_RESET;
		end else begin
			// A bus write wins over a short direct write in the same cycle
			if (dwr && hit_p1) begin
				pointer_one_q <= data_req.wdata;
			end else if (short_wr_now && short_sel_q == 2'd0) begin
				pointer_one_q <= short_wdata_q;
			end
			if (dwr && hit_p2) begin
				pointer_two_q <= data_req.wdata;
			end else if (short_wr_now && short_sel_q == 2'd1) begin
				pointer_two_q <= short_wdata_q;
			end
			if (dwr && hit_s1) begin
				short_reg_one_q <= data_req.wdata;
			end else if (short_wr_now && short_sel_q == 2'd2) begin
				short_reg_one_q <= short_wdata_q;
			end
			if (dwr && hit_s2) begin
				short_reg_second_q <= data_req.wdata;
			end else if (short_wr_now && short_sel_q == 2'd3) begin
				short_reg_second_q <= short_wdata_q;
			end
			if (dwr && hit_acc) begin
				result_reg_q <= data_req.wdata;
			end
			// Bits 7:6 are dropped; software must keep them clear
			if (dwr && hit_sel) begin
				rom_window_select_q <= data_req.wdata[`BLOCK_SELECT_MSB:0];
			end
		end
	end

	// ==========================================================
	// Program counter
	logic [11:0] vector_addr;
	always_comb begin
		unique case (pc_cmd.vec)
			VEC_IRQ0: vector_addr = `IRQ_VECTOR_FIRST;
			VEC_IRQ1: vector_addr = `IRQ_VECTOR_FIRST + 12'h002;
			VEC_IRQ2: vector_addr = `IRQ_VECTOR_FIRST + 12'h004;
			VEC_IRQ3: vector_addr = `IRQ_VECTOR_FIRST + 12'h006;
			VEC_NMI: vector_addr = `NMI_VECTOR;
			VEC_RESET: vector_addr = `RESET_VECTOR;
			default: vector_addr = `RESET_VECTOR;
		endcase
	end

	wire [11:0] rel_offset = {{4{pc_cmd.offset[7]}}, pc_cmd.offset};
	logic [11:0] pc_d;
	always_comb begin
		unique case (pc_cmd.op)
			PC_HOLD: pc_d = pc_q;
			PC_STEP: pc_d = pc_q + 12'h001;
			PC_JUMP: pc_d = pc_cmd.target;
			PC_RELATIVE: pc_d = pc_q + rel_offset;
			PC_VECTOR: pc_d = vector_addr;
			PC_POP: pc_d = pop_addr;
			default: pc_d = pc_q;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pc_q <= `RESET_VECTOR;
		end else begin
			pc_q <= pc_d;
		end
	end

	// Fetch area check: reserved program locations flag the fetch
	wire [11:0] user_first = VARIANT_2K ? `USER_FIRST_2K : `USER_FIRST_1K;
	wire pc_user = pc_q >= user_first && pc_q <= `USER_LAST;
	wire pc_vector = (pc_q >= `IRQ_VECTOR_FIRST && pc_q <= `IRQ_VECTOR_LAST) || pc_q >= `NMI_VECTOR;
	wire pc_reserved = !(pc_user || pc_vector);

	// ==========================================================
	// Program memory and read pipeline
	logic [7:0] window_data;
	logic [7:0] fetch_data;
	logic rd_s1_q;
	logic win_s1_q;
	logic [7:0] reg_s1_q;
	logic fetch_s1_q;
	logic fetch_res_s1_q;

	program_store u_store (
		.ref_clk(ref_clk),
		.load(pm_load),
		.rd_addr_a(window_addr),
		.rd_addr_b(pc_q),
		.rd_data_a(window_data),
		.rd_data_b(fetch_data)
	);

	// Two-stage read keeps every data read at the same latency as a window read
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_s1_q <= 1'b0;
			win_s1_q <= 1'b0;
			reg_s1_q <= 8'h00;
			fetch_s1_q <= 1'b0;
			fetch_res_s1_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 8'h00;
			fetch_valid_q <= 1'b0;
			fetch_data_q <= 8'h00;
			fetch_reserved_q <= 1'b0;
			result_q <= 8'h00;
		end else begin
			rd_s1_q <= data_req.rd;
			win_s1_q <= hit_window;
			reg_s1_q <= reg_rdata;
			fetch_s1_q <= fetch_en;
			fetch_res_s1_q <= pc_reserved;
			rvalid_q <= rd_s1_q;
			rdata_q <= win_s1_q ? window_data : reg_s1_q;
			fetch_valid_q <= fetch_s1_q;
			fetch_data_q <= fetch_data;
			fetch_reserved_q <= fetch_s1_q && fetch_res_s1_q;
			result_q <= result_reg_q;
		end
	end
endmodule : data_space_map

//--- dv/data_space_map_monitor.sv
// Checker on the data space map ports
`timescale 1ns/1ns
module data_space_map_monitor
	import data_space_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire data_space_pkg::data_req_s data_req,
	input wire data_space_pkg::pc_cmd_s pc_cmd,
	input wire logic fetch_en,
	input wire logic [7:0] rdata_q,
	input wire logic rvalid_q,
	input wire logic short_busy_q,
	input wire logic short_done_q,
	input wire logic [7:0] result_q,
	input wire logic [11:0] pc_q,
	input wire logic fetch_valid_q
);
	// ====================
	// Timing relations
	default clocking dcb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire rd_sel = data_req.rd && data_req.addr == 8'hC9;
	wire wr_acc = data_req.wr && data_req.addr == 8'hFF;
	wire is_vec = pc_cmd.op == PC_VECTOR;
	property p_read_lat; data_req.rd |-> ##2 rvalid_q; endproperty
	a_read_lat: assert property (p_read_lat) else $error("read late");
	property p_read_cause; rvalid_q |-> $past(data_req.rd, 2); endproperty
	a_read_cause: assert property (p_read_cause) else $error("stray answer");
	property p_sel_hidden; rd_sel |-> ##2 rdata_q == 8'h00; endproperty
	a_sel_hidden: assert property (p_sel_hidden) else $error("select readable");
	property p_acc; wr_acc ##1 !wr_acc |-> ##1 result_q == $past(data_req.wdata, 2); endproperty
	a_acc: assert property (p_acc) else $error("accumulator copy");
	property p_short; $rose(short_busy_q) |-> short_busy_q[*4] ##1 (!short_busy_q && short_done_q); endproperty
	a_short: assert property (p_short) else $error("short access length");
	property p_fetch; fetch_en |-> ##2 fetch_valid_q; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch late");
	property p_step; pc_cmd.op == PC_STEP |=> pc_q == $past(pc_q) + 12'h001; endproperty
	a_step: assert property (p_step) else $error("step");
	property p_jump; pc_cmd.op == PC_JUMP |=> pc_q == $past(pc_cmd.target); endproperty
	a_jump: assert property (p_jump) else $error("jump");
	property p_nmi; is_vec && pc_cmd.vec == VEC_NMI |=> pc_q == 12'hFFC; endproperty
	a_nmi: assert property (p_nmi) else $error("nmi vector");
	property p_irq; is_vec && pc_cmd.vec <= VEC_IRQ3 |=> pc_q == 12'hFF0 + {9'h000, $past(pc_cmd.vec[1:0]), 1'b0}; endproperty
	a_irq: assert property (p_irq) else $error("irq vector");
endmodule : data_space_map_monitor

bind data_space_map data_space_map_monitor u_mon (.ref_clk, .rst, .data_req, .pc_cmd, .fetch_en, .rdata_q, .rvalid_q,
	.short_busy_q, .short_done_q, .result_q, .pc_q, .fetch_valid_q);

//--- dv/cpu_core_model.sv
// Model of the CPU core issuing data space accesses
`timescale 1ns/1ns
module cpu_core_model
	import data_space_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rvalid_q,
	input wire logic [7:0] rdata_q,
	output data_space_pkg::data_req_s data_req
);
	logic [5:0] image_q;
	initial data_req = '0;
	// Released address and data lines show the inverse of the last value, so a stale match cannot pass
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, input bit slow,
		output logic [7:0] q);
		@(posedge ref_clk) data_req <= '{~w, w, a, d};
		@(posedge ref_clk) data_req <= '{1'b0, 1'b0, ~a, ~d};
		// The read is taken at the release edge; its answer stands only for the cycle after the next edge
		@(posedge ref_clk);
		#1 q = rvalid_q ? rdata_q : 8'hXX;
		if (slow) repeat (3) @(posedge ref_clk);
	endtask : access
	// Image first, so an interrupt between the two writes finds them consistent
	// Called from the main flow only, never from an interrupt context
	task automatic select(input logic [5:0] b);
		logic [7:0] q;
		image_q = b;
		access(1'b1, 8'hC9, {2'b00, b}, 1'b0, q);
	endtask : select
endmodule : cpu_core_model

//--- dv/data_space_map_tb.sv
// Self-checking bench for the data space map
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
`define RDC(a, e) begin cpu.access(1'b0, a, 8'h00, 1'($random(seed)), q); `CHK(q, 8'(e)) end
module data_space_map_tb;
	import data_space_pkg::*;
	logic ref_clk = 0, rst = 1, fetch_en = 0;
	short_req_s short_req = '0;
	pc_cmd_s pc_cmd = '0;
	pm_load_s pm_load = '0;
	logic [11:0] pop_addr = 12'h000;
	wire data_req_s data_req;
	wire [7:0] rdata_q, short_rdata_q, result_q, fetch_data_q;
	wire [11:0] pc_q;
	wire rvalid_q, short_done_q, short_busy_q, fetch_valid_q, fetch_reserved_q;
	int num_errors = 0, checks_done = 0, seed = 32'hEE258021, pm[4096], regs[256], sel_m, pc_m = 'hFFE, n, k;
	logic [7:0] q, d;
	logic [11:0] tbl [12] = '{12'hB9F, 12'hBA0, 12'hF9F, 12'hFA0, 12'hFEF, 12'hFF0, 12'hFF7, 12'hFF8, 12'hFFB,
		12'hFFC, 12'hFFE, 12'hFFF};
	data_space_map #(.VARIANT_2K(1'b0)) DUT (.ref_clk, .rst, .data_req, .short_req, .pc_cmd, .pop_addr, .fetch_en,
		.pm_load, .rdata_q, .rvalid_q, .short_rdata_q, .short_done_q, .short_busy_q, .result_q, .pc_q, .fetch_data_q,
		.fetch_valid_q, .fetch_reserved_q);
	cpu_core_model cpu (.ref_clk, .rvalid_q, .rdata_q, .data_req);
	initial forever #5 ref_clk = ~ref_clk;
	initial begin
		#200000 num_errors++;
		close_out;
	end
	// ====================
	// Tasks
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	task automatic pc_go(input pc_op_e o, input logic [11:0] t, input logic [7:0] f, input vector_e v);
		logic [11:0] p = 12'($random(seed));
		@(posedge ref_clk) pc_cmd <= '{o, t, f, v};
		pop_addr <= p;
		@(posedge ref_clk) pc_cmd.op <= PC_HOLD;
		fetch_en <= 1'b1;
		@(posedge ref_clk) fetch_en <= 1'b0;
		pc_m = o == PC_JUMP ? t : o == PC_STEP ? pc_m + 1 : o == PC_RELATIVE ? pc_m + int'($signed(f)) :
			o == PC_POP ? p : o == PC_VECTOR ? (v == VEC_NMI ? 'hFFC : v == VEC_RESET ? 'hFFE : 'hFF0 + 2 * v) : pc_m;
		pc_m &= 'hFFF;
		@(posedge ref_clk);
		#1 `CHK(pc_q, 12'(pc_m))
		`CHK({fetch_valid_q, fetch_data_q}, {1'b1, 8'(pm[pc_m])})
		`CHK(fetch_reserved_q, !(pc_m >= 'hBA0 && pc_m <= 'hF9F || pc_m >= 'hFF0 && pc_m <= 'hFF7 || pc_m >= 'hFFC))
	endtask : pc_go
	// ====================
	// Main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		#1 `CHK(pc_q, 12'hFFE)
		for (n = 0; n < 4096; n++) begin
			pm[n] = $random(seed) & 'hFF;
			@(posedge ref_clk) pm_load <= '{1'b1, 12'(n), 8'(pm[n])};
		end
		@(posedge ref_clk) pm_load <= '0;
		for (n = 0; n < 6; n++) begin
			sel_m = n == 0 ? 0 : n == 1 ? 63 : $random(seed) & 63;
			cpu.select(6'(sel_m));
			for (k = 0; k < 4; k++) begin
				d = k == 0 ? 8'h40 : k == 1 ? 8'h7F : 8'h40 + 8'($random(seed) & 63);
				`RDC(d, pm[sel_m * 64 + (d & 63)])
			end
		end
		`RDC(8'hC9, 0)
		cpu.access(1'b1, 8'h45, 8'hA5, 1'b0, q);
		`RDC(8'h45, pm[sel_m * 64 + 5])
		`RDC(8'h20, 0)
		for (n = 0; n < 5; n++) begin
			k = n < 4 ? 'h80 + n : 'hFF;
			d = $random(seed);
			regs[k] = d;
			cpu.access(1'b1, 8'(k), d, 1'b0, q);
			`RDC(8'(k), regs[k])
		end
		`CHK(result_q, 8'(regs['hFF]))
		// Second request lands while busy and must be dropped
		for (n = 0; n < 5; n++) begin
			d = $random(seed);
			@(posedge ref_clk) short_req <= '{1'b1, n < 4, 2'(n), d};
			@(posedge ref_clk) short_req.req <= 1'b0;
			#1 for (k = 0; k < 3 && short_busy_q !== 1'b1; k++) @(posedge ref_clk) #1;
			@(posedge ref_clk) short_req <= '{1'b1, 1'b1, 2'(n), ~d};
			@(posedge ref_clk) short_req.req <= 1'b0;
			#1 for (k = 0; k < 8 && short_done_q !== 1'b1; k++) @(posedge ref_clk) #1;
			`CHK({short_done_q, short_busy_q, k[3:0]}, {2'b10, 4'd2})
			`CHK(short_rdata_q, 8'(regs['h80 + n % 4]))
			if (n < 4) regs['h80 + n] = d;
			`RDC(8'h80 + 8'(n % 4), regs['h80 + n % 4])
		end
		foreach (tbl[i]) pc_go(PC_JUMP, tbl[i], 8'h00, VEC_IRQ0);
		pc_go(PC_STEP, 12'h000, 8'h00, VEC_IRQ0);
		for (n = 0; n < 6; n++) pc_go(PC_VECTOR, 12'h000, 8'h00, vector_e'(n));
		for (n = 0; n < 30; n++) begin
			pc_go(pc_op_e'(($random(seed) & 'h7FFF) % 6), 12'($random(seed)), 8'($random(seed)),
				vector_e'(($random(seed) & 'h7FFF) % 6));
		end
		@(posedge ref_clk) rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		#1 `CHK({pc_q, result_q}, {12'hFFE, 8'h00})
		close_out;
	end
endmodule : data_space_map_tb
